// *** rtl/sasfe_device.sv ***
// Functional notes
// - strobes on falling edge, rest rising
// - data drivers enabled combinationally from strobes
// - read is select, read low, write high
// - latch read data at first recognition
// - host ends read by strobe or select
// - write is select and write low
// - commit write 1.5 clocks after recognition
// - selected when both lows 0, high 1
// - dac write lasts three clocks
// - dac latches on rising pair strobe
// - dac code order even A, B, odd A, B
// - signed 10-bit write-only velocity per motor
// - 10-bit readable writable position counts steps
// - current bits 1:0 drive reduce pins
// - current bits 3:2 shift dac word
// - divider bits 1:0 select 1,2,4,8
// - compare bit differs from pos bit9 raises irq
// - motors 1-5 repeat at stride four
// - reset clears all, current loads 1111
`timescale 1ns/1ps
`default_nettype none

module sasfe_device
	import sasfe_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	sasfe_if.device bus,
	output logic [DAC_W-1:0] dac_data,
	output logic dac_channel_sel_lo,
	output logic dac_channel_sel_hi,
	output logic [PAIRS-1:0] dac_pair_write_n,
	output logic [2*MOTORS-1:0] current_reduce_out,
	output logic [2*MOTORS-1:0] phase_out
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [3:0] table_index(input logic [POS_W-1:0] pos);
		table_index = pos[POS_MIRROR_BIT] ? ~pos[3:0] : pos[3:0];
	endfunction

	function automatic logic [DAC_W-1:0] dac_shift(input logic [TABLE_W-1:0] w, input logic [1:0] sh);
		logic [DAC_W-1:0] r;
		r = {w, 2'b00} >> sh;
		if (sh == 2'h3) begin
			r = {2'b00, w};
			r[DAC_MASK_BIT] = 1'b0;
		end
		dac_shift = r;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [4:0] strobe_s1;
	logic [4:0] strobe_s2;
	logic [ADDR_W-1:0] addr_s1;
	logic [ADDR_W-1:0] addr_s2;
	logic [DATA_W-1:0] data_s1;
	logic [DATA_W-1:0] data_s2;

	always_ff @(negedge mclk) begin
		if (rst) begin
			strobe_s1 <= STROBE_IDLE;
			strobe_s2 <= STROBE_IDLE;
		end else begin
			strobe_s1 <= {bus.select_low_a, bus.select_low_b, bus.select_high, bus.read_strobe_n,
				bus.write_strobe_n};
			strobe_s2 <= strobe_s1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			addr_s1 <= '0;
			addr_s2 <= '0;
			data_s1 <= '0;
			data_s2 <= '0;
		end else begin
			addr_s1 <= bus.addr;
			addr_s2 <= addr_s1;
			data_s1 <= bus.data_bus;
			data_s2 <= data_s1;
		end
	end

	// ****************************************
	// access recognition
	// ****************************************
	logic sel_seen;
	logic rd_seen;
	logic wr_seen;
	logic rd_p1;
	logic wr_p1;
	logic wr_p2;
	logic capture;
	logic commit;

	assign sel_seen = ~strobe_s2[4] & ~strobe_s2[3] & strobe_s2[2];
	assign rd_seen = sel_seen & ~strobe_s2[1] & strobe_s2[0];
	assign wr_seen = sel_seen & ~strobe_s2[0];
	assign capture = rd_seen & ~rd_p1;
	// half clock to the next rise, one more to commit
	assign commit = wr_p1 & ~wr_p2;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_p1 <= 1'b0;
			wr_p1 <= 1'b0;
			wr_p2 <= 1'b0;
		end else begin
			rd_p1 <= rd_seen;
			wr_p1 <= wr_seen;
			wr_p2 <= wr_p1;
		end
	end

	// ****************************************
	// address decode
	// ****************************************
	logic motor_hit;
	logic table_hit;
	logic [2:0] reg_motor;
	logic [1:0] reg_field;

	// motor n sits at n times the stride
	assign motor_hit = addr_s2 < MOTOR_REG_END;
	assign reg_motor = addr_s2[4:2];
	assign reg_field = addr_s2[1:0];
	assign table_hit = addr_s2[5:4] == TABLE_BASE_HI;

	// ****************************************
	// motor registers
	// ****************************************
	logic [VEL_W-1:0] velocity [MOTORS];
	logic [POS_W-1:0] position [MOTORS];
	logic [3:0] current [MOTORS];
	logic [2:0] divider [MOTORS];
	logic [MOTORS-1:0] step;
	logic [MOTORS-1:0] step_up;
	logic [MOTORS-1:0] cmp_mismatch;

	for (genvar m = 0; m < MOTORS; m++) begin : g_motor
		logic hit;
		logic [POS_W-1:0] next_position;

		assign hit = commit & motor_hit & (reg_motor == 3'(m));
		// count microsteps in the velocity sign's direction
		assign next_position = step_up[m] ? position[m] + 10'h001 : position[m] - 10'h001;
		assign cmp_mismatch[m] = divider[m][DIV_CMP_BIT] ^ position[m][POS_CMP_BIT];

		always_ff @(posedge mclk) begin
			if (rst) begin
				velocity[m] <= VELOCITY_RESET;
				current[m] <= CURRENT_RESET;
				divider[m] <= DIVIDER_RESET;
			end else if (hit) begin
				if (reg_field == REG_VELOCITY) begin
					velocity[m] <= data_s2[VEL_W-1:0];
				end
				if (reg_field == REG_CURRENT) begin
					current[m] <= data_s2[3:0];
				end
				if (reg_field == REG_DIVIDER) begin
					divider[m] <= data_s2[2:0];
				end
			end
		end

		// host write wins over a step in the same cycle
		always_ff @(posedge mclk) begin
			if (rst) begin
				position[m] <= POSITION_RESET;
			end else if (hit && reg_field == REG_POSITION) begin
				position[m] <= data_s2[POS_W-1:0];
			end else if (step[m]) begin
				position[m] <= next_position;
			end
		end

		// pulse rate from velocity and divider
		sasfe_pulse_gen #(
			.VW(VEL_W),
			.AW(ACC_W)
		) u_pulse (
			.mclk(mclk),
			.rst(rst),
			.velocity(velocity[m]),
			.div_sel(divider[m][DIV_SEL_LSB +: 2]),
			.step(step[m]),
			.step_up(step_up[m])
		);

		// current reduce pins follow register bits
		always_ff @(posedge mclk) begin
			if (rst) begin
				current_reduce_out[2*m +: 2] <= CURRENT_RESET[CUR_REDUCE_LSB +: 2];
				phase_out[2*m +: 2] <= 2'b00;
			end else begin
				current_reduce_out[2*m +: 2] <= current[m][CUR_REDUCE_LSB +: 2];
				phase_out[2*m +: 2] <= {position[m][POS_SIGN_BIT],
					next_quarter(position[m])};
			end
		end
	end

	function automatic logic next_quarter(input logic [POS_W-1:0] pos);
		logic [POS_W-1:0] shifted;
		shifted = pos + QUARTER_OFFSET;
		next_quarter = shifted[POS_SIGN_BIT];
	endfunction

	// ****************************************
	// microstep table
	// ****************************************
	logic [TABLE_W-1:0] step_table [TABLE_DEPTH];

	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < TABLE_DEPTH; i++) begin
				step_table[i] <= TABLE_RESET;
			end
		end else if (commit && table_hit) begin
			step_table[addr_s2[3:0]] <= data_s2[TABLE_DATA_LSB +: TABLE_W];
		end
	end

	// ****************************************
	// host read path and interrupt
	// ****************************************
	logic [DATA_W-1:0] read_word;
	logic [DATA_W-1:0] read_latch;
	logic irq_n;

	// write-only registers read as zero
	assign read_word = (motor_hit && reg_field == REG_POSITION) ? DATA_W'(position[reg_motor]) : READ_ZERO;

	// held until the next read starts
	always_ff @(posedge mclk) begin
		if (rst) begin
			read_latch <= '0;
			irq_n <= 1'b1;
		end else begin
			if (capture) begin
				read_latch <= read_word;
			end
			// any motor mismatch pulls irq low
			irq_n <= ~|cmp_mismatch;
		end
	end

	assign bus.dev_data_out = read_latch;
	assign bus.irq_out_n = irq_n;
	// drivers follow raw pins, no clock in the path
	assign bus.dev_data_oe = ~bus.select_low_a & ~bus.select_low_b & bus.select_high & ~bus.read_strobe_n &
		bus.write_strobe_n;

	// ****************************************
	// dac sequencer
	// ****************************************
	logic [1:0] slot_clk;
	logic [1:0] code;
	logic [1:0] pair;
	logic [2:0] dac_motor;
	logic [POS_W-1:0] dac_pos;
	logic [DAC_W-1:0] dac_word;
	logic [PAIRS-1:0] pair_onehot;

	// code bit 1 picks odd motor, bit 0 picks phase B
	assign dac_motor = 3'({pair, code[1]});
	assign dac_pos = code[0] ? position[dac_motor] + QUARTER_OFFSET : position[dac_motor];
	assign dac_word = dac_shift(step_table[table_index(dac_pos)], current[dac_motor][CUR_SHIFT_LSB +: 2]);
	assign pair_onehot = PAIRS'(3'h1 << pair);

	// walk four codes, then move on to the next pair
	always_ff @(posedge mclk) begin
		if (rst) begin
			slot_clk <= 2'h0;
			code <= 2'h0;
			pair <= 2'h0;
		end else if (slot_clk == DAC_SLOT_LAST) begin
			slot_clk <= 2'h0;
			code <= code + 2'h1;
			if (code == 2'(DAC_CODES - 1)) begin
				pair <= (pair == 2'(PAIRS - 1)) ? 2'h0 : pair + 2'h1;
			end
		end else begin
			slot_clk <= slot_clk + 2'h1;
		end
	end

	// strobe low two clocks, high in the third with data still stable
	always_ff @(posedge mclk) begin
		if (rst) begin
			dac_data <= '0;
			dac_channel_sel_lo <= 1'b0;
			dac_channel_sel_hi <= 1'b0;
			dac_pair_write_n <= '1;
		end else begin
			// word taken once per slot, so a table, current or step change cannot move it under the strobe
			if (slot_clk == 2'h0) begin
				dac_data <= dac_word;
			end
			dac_channel_sel_lo <= code[0];
			dac_channel_sel_hi <= code[1];
			dac_pair_write_n <= (slot_clk != DAC_SLOT_LAST) ? ~pair_onehot : '1;
		end
	end

endmodule

`default_nettype wire

// *** rtl/sasfe_pkg.sv ***
package sasfe_pkg;

	// ****************************************
	// geometry
	// ****************************************
	localparam int MOTORS = 6;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int VEL_W = 10;
	localparam int POS_W = 10;
	localparam int ACC_W = 14;
	localparam int TABLE_DEPTH = 16;
	localparam int TABLE_W = 6;
	localparam int DAC_W = 8;
	localparam int PAIRS = 3;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [1:0] REG_VELOCITY = 2'h0;
	localparam logic [1:0] REG_POSITION = 2'h1;
	localparam logic [1:0] REG_CURRENT = 2'h2;
	localparam logic [1:0] REG_DIVIDER = 2'h3;
	localparam logic [5:0] REG_STRIDE = 6'h04;
	localparam logic [5:0] MOTOR_REG_END = 6'h18;
	localparam logic [1:0] TABLE_BASE_HI = 2'h3;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CUR_REDUCE_LSB = 0;
	localparam int CUR_SHIFT_LSB = 2;
	localparam int DIV_SEL_LSB = 0;
	localparam int DIV_CMP_BIT = 2;
	localparam int POS_CMP_BIT = 9;
	localparam int POS_MIRROR_BIT = 4;
	localparam int POS_SIGN_BIT = 5;
	localparam int TABLE_DATA_LSB = 2;
	localparam int DAC_MASK_BIT = 5;
	localparam logic [POS_W-1:0] QUARTER_OFFSET = 10'h010;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [VEL_W-1:0] VELOCITY_RESET = 10'h000;
	localparam logic [POS_W-1:0] POSITION_RESET = 10'h000;
	localparam logic [3:0] CURRENT_RESET = 4'hf;
	localparam logic [2:0] DIVIDER_RESET = 3'h0;
	localparam logic [TABLE_W-1:0] TABLE_RESET = 6'h00;
	// {select_low_a, select_low_b, select_high, read_strobe_n, write_strobe_n}
	localparam logic [4:0] STROBE_IDLE = 5'h1b;

	// ****************************************
	// timing counts in system clocks
	// ****************************************
	localparam int DAC_SLOT_CLKS = 3;
	localparam int DAC_CODES = 4;
	localparam int DAC_PERIOD_CLKS = DAC_SLOT_CLKS * DAC_CODES;
	localparam logic [1:0] DAC_SLOT_LAST = 2'(DAC_SLOT_CLKS - 1);
	localparam logic [1:0] HOST_WR_LOW = 2'h3;
	localparam logic [1:0] HOST_RD_LOW = 2'h3;

endpackage

// *** rtl/sasfe_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface sasfe_if;
	import sasfe_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] host_data_out;
	logic host_data_oe;
	logic [DATA_W-1:0] dev_data_out;
	logic dev_data_oe;
	logic select_low_a;
	logic select_low_b;
	logic select_high;
	logic read_strobe_n;
	logic write_strobe_n;
	logic irq_out_n;
	wire [DATA_W-1:0] data_bus;

	// shared data wire resolved from the two enables; a released bus reads as zero
	assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : '0);

	modport device(input addr, data_bus, select_low_a, select_low_b, select_high, read_strobe_n,
		write_strobe_n, output dev_data_out, dev_data_oe, irq_out_n);
	modport host(output addr, host_data_out, host_data_oe, select_low_a, select_low_b, select_high,
		read_strobe_n, write_strobe_n, input data_bus, irq_out_n);
endinterface

`default_nettype wire

// *** rtl/sasfe_pulse_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

module sasfe_pulse_gen
	import sasfe_pkg::*;
#(
	parameter int VW = VEL_W,
	parameter int AW = ACC_W
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [VW-1:0] velocity,
	input wire logic [1:0] div_sel,
	output logic step,
	output logic step_up
);
	logic [2:0] prescale;
	logic [AW-1:0] acc;
	logic [2:0] div_mask;
	logic tick;
	logic [VW-1:0] magnitude;
	logic [AW:0] next_sum;

	// divide by 1, 2, 4 or 8
	assign div_mask = {&div_sel, div_sel[1], |div_sel};
	assign tick = (prescale & div_mask) == 3'h0;
	// two's complement magnitude; -512 maps to 512, still fits unsigned
	assign magnitude = velocity[VW-1] ? VW'(~velocity + 1'b1) : velocity;
	assign next_sum = {1'b0, acc} + (AW+1)'(magnitude);

	always_ff @(posedge mclk) begin
		if (rst) begin
			prescale <= 3'h0;
			acc <= '0;
			step <= 1'b0;
			step_up <= 1'b1;
		end else begin
			prescale <= prescale + 3'h1;
			if (tick) begin
				acc <= next_sum[AW-1:0];
			end
			step <= tick & next_sum[AW];
			step_up <= ~velocity[VW-1];
		end
	end
endmodule

`default_nettype wire

// *** rtl/sasfe_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module sasfe_host
	import sasfe_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	sasfe_if.host bus,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic irq_pending
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_STROBE = 4'h4,
		ST_RELEASE = 4'h8
	} sasfe_host_state_type;

	sasfe_host_state_type state;
	logic is_write;
	logic [1:0] cnt;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic data_oe;
	logic selected;
	logic rd_n;
	logic wr_n;

	assign bus.addr = addr;
	assign bus.host_data_out = wdata;
	assign bus.host_data_oe = data_oe;
	assign bus.select_low_a = ~selected;
	assign bus.select_low_b = ~selected;
	assign bus.select_high = selected;
	assign bus.read_strobe_n = rd_n;
	assign bus.write_strobe_n = wr_n;

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			is_write <= 1'b0;
			cnt <= 2'h0;
			addr <= '0;
			wdata <= '0;
			data_oe <= 1'b0;
			selected <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			req_ready <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			irq_pending <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			irq_pending <= ~bus.irq_out_n;
			case (state)
				ST_IDLE: begin
					if (req_valid) begin
						is_write <= req_write;
						addr <= req_addr;
						wdata <= req_wdata;
						data_oe <= req_write;
						selected <= 1'b1;
						req_ready <= 1'b0;
						state <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					// only one strobe low at a time
					rd_n <= is_write;
					wr_n <= ~is_write;
					cnt <= is_write ? HOST_WR_LOW : HOST_RD_LOW;
					state <= ST_STROBE;
				end
				ST_STROBE: begin
					if (cnt == 2'h0) begin
						// end the access by the strobe, select held one more clock
						rd_n <= 1'b1;
						wr_n <= 1'b1;
						if (!is_write) begin
							rsp_rdata <= bus.data_bus;
							rsp_valid <= 1'b1;
						end
						state <= ST_RELEASE;
					end else begin
						cnt <= cnt - 2'h1;
					end
				end
				ST_RELEASE: begin
					selected <= 1'b0;
					data_oe <= 1'b0;
					req_ready <= 1'b1;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

// *** sim/sasfe_link_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module sasfe_link_asserts
	import sasfe_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic select_low_a,
	input wire logic select_low_b,
	input wire logic select_high,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic dev_data_oe,
	input wire logic [DATA_W-1:0] dev_data_out,
	input wire logic irq_out_n,
	input wire logic [DAC_W-1:0] dac_data,
	input wire logic dac_channel_sel_lo,
	input wire logic dac_channel_sel_hi,
	input wire logic [PAIRS-1:0] dac_pair_write_n
);
	wire logic sel = !select_low_a && !select_low_b && select_high;
	wire logic rd_acc = sel && !read_strobe_n && write_strobe_n;
	// idle means no pair strobe is low
	wire logic idle = (dac_pair_write_n == 3'h7);
	wire logic [1:0] code = {dac_channel_sel_hi, dac_channel_sel_lo};

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// ****************************************
	// host bus
	// ****************************************
	property p_oe_comb;
		dev_data_oe == rd_acc;
	endproperty
	a_oe_comb: assert property (p_oe_comb)
		else $error("data enable does not follow select and strobes");
	property p_wr_no_oe;
		(sel && !write_strobe_n) |-> !dev_data_oe;
	endproperty
	a_wr_no_oe: assert property (p_wr_no_oe)
		else $error("data driven during a write");
	// capture lands within two clocks, so from the fourth cycle on the latch must hold
	property p_read_hold;
		(rd_acc && $past(rd_acc) && $past(rd_acc, 2) && $past(rd_acc, 3)) |-> $stable(dev_data_out);
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("read latch changed within an access");
	property p_reset_idle;
		$fell(rst) |-> idle && irq_out_n && !dev_data_oe;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs not idle after reset");

	// ****************************************
	// dac link
	// ****************************************
	property p_dac_slot;
		$fell(idle) |-> ##1 !idle ##1 idle ##1 !idle;
	endproperty
	a_dac_slot: assert property (p_dac_slot)
		else $error("dac slot is not two low and one high");
	property p_dac_code;
		$rose(idle) |=> (code == 2'($past(code) + 2'h1));
	endproperty
	a_dac_code: assert property (p_dac_code)
		else $error("dac channel code out of order");
	property p_dac_pair;
		$onehot0(~dac_pair_write_n) and
			(($fell(idle) && code != 2'h0) |-> dac_pair_write_n == $past(dac_pair_write_n, 3));
	endproperty
	a_dac_pair: assert property (p_dac_pair)
		else $error("dac pair changed inside a period");
	property p_dac_stable;
		$rose(idle) |-> $stable(dac_data) && $stable(code) && ($past(dac_data) == $past(dac_data, 2));
	endproperty
	a_dac_stable: assert property (p_dac_stable)
		else $error("dac word moved before the strobe rose");

	c_read: cover property (rd_acc ##1 !rd_acc);
	c_write: cover property (sel && !write_strobe_n);
	c_dac_wrap: cover property ($rose(idle) && code == 2'h3);
endmodule

`default_nettype wire

// *** sim/six_axis_stepper_front_end_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module six_axis_stepper_front_end_bench;
	import sasfe_pkg::*;
	typedef struct packed {
		logic [15:0] lo;
		logic [15:0] hi;
	} sasfe_note_type;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [ADDR_W-1:0] req_addr = 6'h00;
	logic [DATA_W-1:0] req_wdata = 16'h0000;
	logic req_ready;
	logic rsp_valid;
	logic [DATA_W-1:0] rsp_rdata;
	logic irq_pending;
	logic [DAC_W-1:0] dac_data;
	logic dac_channel_sel_lo;
	logic dac_channel_sel_hi;
	logic [PAIRS-1:0] dac_pair_write_n;
	logic [2*MOTORS-1:0] current_reduce_out;
	logic [2*MOTORS-1:0] phase_out;
	logic [31:0] seed = 32'h864c8333;
	logic [15:0] d;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	sasfe_note_type notes[$];
	sasfe_note_type note;
	logic [5:0] zaddr [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h18, 6'h2f};
	logic [7:0] dac_exp [4] = '{8'hfc, 8'h7e, 8'h3f, 8'h1f};
	logic [5:0] irq_a [4] = '{6'h0b, 6'h09, 6'h0b, 6'h09};
	logic [15:0] irq_d [4] = '{16'h0004, 16'h0200, 16'h0000, 16'h0000};
	logic irq_e [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	sasfe_if bus_if();

	always #2.5 mclk = ~mclk;

	sasfe_device sasfe_device_inst (
		.mclk(mclk),
		.rst(rst),
		.bus(bus_if),
		.dac_data(dac_data),
		.dac_channel_sel_lo(dac_channel_sel_lo),
		.dac_channel_sel_hi(dac_channel_sel_hi),
		.dac_pair_write_n(dac_pair_write_n),
		.current_reduce_out(current_reduce_out),
		.phase_out(phase_out)
	);
	sasfe_host sasfe_host_inst (
		.mclk(mclk),
		.rst(rst),
		.bus(bus_if),
		.req_valid(req_valid),
		.req_write(req_write),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.irq_pending(irq_pending)
	);
	sasfe_link_asserts sasfe_link_asserts_inst (
		.mclk(mclk),
		.rst(rst),
		.select_low_a(bus_if.select_low_a),
		.select_low_b(bus_if.select_low_b),
		.select_high(bus_if.select_high),
		.read_strobe_n(bus_if.read_strobe_n),
		.write_strobe_n(bus_if.write_strobe_n),
		.dev_data_oe(bus_if.dev_data_oe),
		.dev_data_out(bus_if.dev_data_out),
		.irq_out_n(bus_if.irq_out_n),
		.dac_data(dac_data),
		.dac_channel_sel_lo(dac_channel_sel_lo),
		.dac_channel_sel_hi(dac_channel_sel_hi),
		.dac_pair_write_n(dac_pair_write_n)
	);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] seen);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic check_rng(input string name, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] seen);
		checks++;
		if ((seen >= lo) !== 1'b1 || (seen <= hi) !== 1'b1) begin
			n_errors++;
			$display("Error %s expected %h..%h seen %h", name, lo, hi, seen);
		end
	endtask
	// request is held until the take edge, then the task waits for ready under a bound
	task automatic host_req(input logic wr, input logic [5:0] a, input logic [15:0] dat);
		int n;
		n = 0;
		req_valid = 1'b1;
		req_write = wr;
		req_addr = a;
		req_wdata = dat;
		tick(1);
		req_valid = 1'b0;
		while (req_ready !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] lo, input logic [15:0] hi);
		notes.push_back('{lo, hi});
		host_req(1'b0, a, 16'h0000);
	endtask
	// motor 1 keeps its reset current, so codes 2 and 3 carry the fully masked word
	task automatic dac_watch(input logic [7:0] exp0);
		tick(40);
		repeat (36) begin
			if (dac_pair_write_n[0] === 1'b0)
				check_val("dac_data", {8'h00, dac_channel_sel_hi ? 8'h1f : exp0}, {8'h00, dac_data});
			tick(1);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge mclk) begin
		if (rsp_valid === 1'b1) begin
			if (notes.size() == 0) begin
				n_errors++;
				$display("Error rsp_valid expected none seen one");
			end else begin
				note = notes.pop_front();
				check_rng("rsp_rdata", note.lo, note.hi, rsp_rdata);
			end
		end
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			wrap_up();
		end
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		tick(12);
		rst = 1'b0;
		tick(2);
		check_val("current_reduce_out", 16'h0fff, {4'h0, current_reduce_out});
		check_val("irq_pending", 16'h0000, {15'h0, irq_pending});
		for (int m = 0; m < MOTORS; m++) begin
			d = 16'(rnd());
			rd(6'(4 * m + 1), 16'h0000, 16'h0000);
			host_req(1'b1, 6'(4 * m + 1), d);
			// phase A sign is position bit 5, phase B sign is bit 5 a quarter further on
			check_val("phase_out", {14'h0, d[5], d[5] ^ d[4]}, {14'h0, phase_out[2 * m +: 2]});
			rd(6'(4 * m + 1), {6'h00, d[9:0]}, {6'h00, d[9:0]});
			host_req(1'b1, 6'(4 * m + 1), 16'h0000);
		end
		host_req(1'b1, 6'h18, 16'hffff);
		host_req(1'b1, 6'h2f, 16'hffff);
		foreach (zaddr[i]) rd(zaddr[i], 16'h0000, 16'h0000);
		for (int i = 0; i < TABLE_DEPTH; i++) host_req(1'b1, 6'(48 + i), 16'h00fc);
		for (int s = 0; s < 4; s++) begin
			host_req(1'b1, 6'h02, 16'(5 * s));
			check_val("current_reduce_out", {14'h0, 2'(s)}, {14'h0, current_reduce_out[1:0]});
			dac_watch(dac_exp[s]);
		end
		foreach (irq_a[i]) begin
			host_req(1'b1, irq_a[i], irq_d[i]);
			tick(4);
			check_val("irq_pending", {15'h0, irq_e[i]}, {15'h0, irq_pending});
		end
		// about 4100 clocks at speed 511 give 128 steps before division; carry slack is 3
		for (int k = 0; k < 5; k++) begin
			host_req(1'b1, 6'h0f, 16'(k % 4));
			host_req(1'b1, 6'h0d, 16'h0000);
			host_req(1'b1, 6'h0c, (k == 4) ? 16'h0201 : 16'h01ff);
			tick(4096);
			host_req(1'b1, 6'h0c, 16'h0000);
			d = (k == 4) ? 16'h0380 : 16'(128 >> k);
			rd(6'h0d, d - 16'h0003, d + 16'h0003);
		end
		tick(10);
		wrap_up();
	end
endmodule

`default_nettype wire
